// >>> rtl/shed_pkg.sv
// Package of register map, field layout, reset values and timing for rail-one phase shedding.
package shed_pkg;
    // Register offsets on the management bus.
    localparam logic [7:0] ADDR_CONTROL = 8'h20;
    localparam logic [7:0] ADDR_HOLDOFF = 8'h21;
    localparam logic [7:0] ADDR_WINDOW = 8'h22;
    localparam logic [7:0] ADDR_L1_HIGH = 8'h23;
    localparam logic [7:0] ADDR_L1_LOW = 8'h24;
    localparam logic [7:0] ADDR_L2_HIGH = 8'h25;
    localparam logic [7:0] ADDR_L2_LOW = 8'h26;
    // Control register field positions.
    localparam int BIT_SHED_EN = 5;
    localparam int BIT_AUTO_SKIP = 4;
    localparam int BIT_PS1_MIN_LO = 2;
    localparam int BIT_SHED_MIN_LO = 0;
    localparam logic [7:0] CONTROL_MASK = 8'h3f;
    // Reset values.
    localparam logic [7:0] RST_CONTROL = 8'h15;
    localparam logic [7:0] RST_HOLDOFF = 8'h0f;
    localparam logic [7:0] RST_WINDOW = 8'h0f;
    localparam logic [7:0] RST_LEVEL = 8'h00;
    // Timing: one holdoff or window unit, and the system clock.
    localparam int UNIT_MS = 4;
    localparam int CLK_HZ = 50_000_000;
    localparam int UNIT_CYCLES = UNIT_MS * (CLK_HZ / 1000);
    // Phase count encoding on the output.
    localparam logic [1:0] PHASES_ONE = 2'h1;
    localparam logic [1:0] PHASES_TWO = 2'h2;
    localparam logic [1:0] PHASES_THREE = 2'h3;
    // Power state codes carried by the power state command.
    localparam logic [1:0] PSTATE_ZERO = 2'h0;
    localparam logic [1:0] PSTATE_ONE = 2'h1;
    localparam logic [1:0] PSTATE_TWO = 2'h2;
    localparam logic [1:0] PSTATE_THREE = 2'h3;
    // Shedding level state and the pending step direction.
    typedef enum logic [1:0] {LVL_ONE, LVL_TWO, LVL_THREE} level_t;
    typedef enum logic [1:0] {STEP_NONE, STEP_UP, STEP_DOWN} step_t;
endpackage

// >>> rtl/shed_timing_if.sv
// Interface between the shedding controller and its holdoff and window timer.
interface shed_timing_if;
    logic [7:0] holdoff_len;
    logic [7:0] window_len;
    logic soft_start_done;
    logic win_run;
    logic win_restart;
    logic holdoff_done;
    logic win_expired;
    modport ctrl (output holdoff_len, output window_len, output soft_start_done,
        output win_run, output win_restart, input holdoff_done, input win_expired);
    modport timer (input holdoff_len, input window_len, input soft_start_done,
        input win_run, input win_restart, output holdoff_done, output win_expired);
endinterface

// >>> rtl/shed_timer.sv
// Unit prescaler, post-soft-start holdoff counter and detection window counter.
module shed_timer #(
    parameter int TICK_CYCLES = shed_pkg::UNIT_CYCLES
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Timing handshake with the controller.
    shed_timing_if.timer tif
);
    import shed_pkg::*;

    localparam int PW = $clog2(TICK_CYCLES + 1);
    localparam logic [PW-1:0] TICK_LAST = PW'(TICK_CYCLES - 1);

    logic [PW-1:0] pre_ff, nxt_pre;
    logic [7:0] hold_cnt_ff, nxt_hold_cnt;
    logic hold_done_ff, nxt_hold_done;
    logic [7:0] win_cnt_ff, nxt_win_cnt;
    logic win_exp_ff, nxt_win_exp;
    logic tick;

    // Free-running prescaler; windows may start mid-unit, so they carry up to one unit of jitter.
    always_comb begin
        tick = (pre_ff == TICK_LAST);
        nxt_pre = tick ? '0 : pre_ff + PW'(1);
    end

    // Holdoff counts units once soft start is done, and rearms whenever soft start drops.
    always_comb begin
        nxt_hold_cnt = hold_cnt_ff;
        nxt_hold_done = hold_done_ff;
        if (!tif.soft_start_done) begin
            nxt_hold_cnt = 8'h00;
            nxt_hold_done = 1'b0;
        end else if (hold_cnt_ff >= tif.holdoff_len) begin
            nxt_hold_done = 1'b1;
        end else if (tick) begin
            nxt_hold_cnt = hold_cnt_ff + 8'h01;
        end
    end

    // Window counts units while a condition persists and restarts when it clears or changes.
    always_comb begin
        nxt_win_cnt = win_cnt_ff;
        nxt_win_exp = 1'b0;
        if (!tif.win_run || tif.win_restart) begin
            nxt_win_cnt = 8'h00;
        end else if (win_cnt_ff >= tif.window_len) begin
            nxt_win_exp = !win_exp_ff;
        end else if (tick) begin
            nxt_win_cnt = win_cnt_ff + 8'h01;
        end
    end

    // State registers.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pre_ff <= '0;
            hold_cnt_ff <= 8'h00;
            hold_done_ff <= 1'b0;
            win_cnt_ff <= 8'h00;
            win_exp_ff <= 1'b0;
        end else begin
            pre_ff <= nxt_pre;
            hold_cnt_ff <= nxt_hold_cnt;
            hold_done_ff <= nxt_hold_done;
            win_cnt_ff <= nxt_win_cnt;
            win_exp_ff <= nxt_win_exp;
        end
    end

    assign tif.holdoff_done = hold_done_ff;
    assign tif.win_expired = win_exp_ff;
endmodule

// >>> rtl/rail1_phase_shedding_regs.sv
// Rail-one dynamic phase shedding: register bank, level state machine and phase count output.
module rail1_phase_shedding_regs
    import shed_pkg::*;
#(
    parameter int TICK_CYCLES = shed_pkg::UNIT_CYCLES,
    parameter logic [1:0] MAX_PHASES = shed_pkg::PHASES_THREE
) (
    // Clock and reset.
    input wire logic I_CLK,
    input wire logic I_RST_N,
    // Byte register port from the management bus engine.
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    output logic [7:0] O_REG_RDATA,
    // Power state command and regulator status.
    input wire logic I_PS_CMD,
    input wire logic [1:0] I_PS_CODE,
    input wire logic I_SOFT_START_DONE,
    input wire logic [7:0] I_LOAD_CURRENT,
    // Phase control outputs.
    output logic [1:0] O_ACTIVE_PHASES,
    output logic O_PULSE_SKIP,
    output logic O_SHED_ACTIVE
);
    import shed_pkg::*;

    // Decode a minimum phase field; codes 00 and 01 both mean a single phase.
    function automatic logic [1:0] min_phases(input logic [1:0] code);
        min_phases = (code == 2'h0) ? PHASES_ONE : code;
    endfunction

    // Larger of two phase counts, then limited to the phases fitted on the board.
    function automatic logic [1:0] pick_phases(input logic [1:0] a, input logic [1:0] b);
        logic [1:0] m;
        m = (a > b) ? a : b;
        pick_phases = (m > MAX_PHASES) ? MAX_PHASES : m;
    endfunction

    shed_timing_if tif ();

    shed_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .i_clk(I_CLK),
        .i_rst_n(I_RST_N),
        .tif(tif)
    );

    logic [7:0] control_ff, nxt_control;
    logic [7:0] holdoff_ff, nxt_holdoff;
    logic [7:0] window_ff, nxt_window;
    logic [7:0] l1_high_ff, nxt_l1_high;
    logic [7:0] l1_low_ff, nxt_l1_low;
    logic [7:0] l2_high_ff, nxt_l2_high;
    logic [7:0] l2_low_ff, nxt_l2_low;
    logic [7:0] rdata_ff, nxt_rdata;
    logic [1:0] pstate_ff, nxt_pstate;

    // Register writes and read data; unmapped reads return zero and reserved bits read zero.
    always_comb begin
        nxt_control = control_ff;
        nxt_holdoff = holdoff_ff;
        nxt_window = window_ff;
        nxt_l1_high = l1_high_ff;
        nxt_l1_low = l1_low_ff;
        nxt_l2_high = l2_high_ff;
        nxt_l2_low = l2_low_ff;
        nxt_rdata = rdata_ff;
        if (I_REG_WR) begin
            if (I_REG_ADDR == ADDR_CONTROL) begin
                nxt_control = I_REG_WDATA & CONTROL_MASK;
            end else if (I_REG_ADDR == ADDR_HOLDOFF) begin
                nxt_holdoff = I_REG_WDATA;
            end else if (I_REG_ADDR == ADDR_WINDOW) begin
                nxt_window = I_REG_WDATA;
            end else if (I_REG_ADDR == ADDR_L1_HIGH) begin
                nxt_l1_high = I_REG_WDATA;
            end else if (I_REG_ADDR == ADDR_L1_LOW) begin
                nxt_l1_low = I_REG_WDATA;
            end else if (I_REG_ADDR == ADDR_L2_HIGH) begin
                nxt_l2_high = I_REG_WDATA;
            end else if (I_REG_ADDR == ADDR_L2_LOW) begin
                nxt_l2_low = I_REG_WDATA;
            end
        end
        if (I_REG_RD) begin
            if (I_REG_ADDR == ADDR_CONTROL) begin
                nxt_rdata = control_ff;
            end else if (I_REG_ADDR == ADDR_HOLDOFF) begin
                nxt_rdata = holdoff_ff;
            end else if (I_REG_ADDR == ADDR_WINDOW) begin
                nxt_rdata = window_ff;
            end else if (I_REG_ADDR == ADDR_L1_HIGH) begin
                nxt_rdata = l1_high_ff;
            end else if (I_REG_ADDR == ADDR_L1_LOW) begin
                nxt_rdata = l1_low_ff;
            end else if (I_REG_ADDR == ADDR_L2_HIGH) begin
                nxt_rdata = l2_high_ff;
            end else if (I_REG_ADDR == ADDR_L2_LOW) begin
                nxt_rdata = l2_low_ff;
            end else begin
                nxt_rdata = 8'h00;
            end
        end
        nxt_pstate = I_PS_CMD ? I_PS_CODE : pstate_ff;
    end

    // Register bank storage.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            control_ff <= RST_CONTROL;
            holdoff_ff <= RST_HOLDOFF;
            window_ff <= RST_WINDOW;
            l1_high_ff <= RST_LEVEL;
            l1_low_ff <= RST_LEVEL;
            l2_high_ff <= RST_LEVEL;
            l2_low_ff <= RST_LEVEL;
            rdata_ff <= 8'h00;
            pstate_ff <= PSTATE_ZERO;
        end else begin
            control_ff <= nxt_control;
            holdoff_ff <= nxt_holdoff;
            window_ff <= nxt_window;
            l1_high_ff <= nxt_l1_high;
            l1_low_ff <= nxt_l1_low;
            l2_high_ff <= nxt_l2_high;
            l2_low_ff <= nxt_l2_low;
            rdata_ff <= nxt_rdata;
            pstate_ff <= nxt_pstate;
        end
    end

    level_t level_ff, nxt_level;
    step_t step, step_ff;
    logic moved_ff, nxt_moved;
    logic shed_on, ps_low, auto_skip;
    logic [1:0] floor_ph, lvl_ph;
    logic [1:0] phases_ff, nxt_phases;
    logic skip_ff, nxt_skip;
    logic active_ff;

    // Load is in units of max current / 256; above a high level means load > value units.
    always_comb begin
        shed_on = control_ff[BIT_SHED_EN] && tif.holdoff_done;
        ps_low = (pstate_ff == PSTATE_TWO) || (pstate_ff == PSTATE_THREE);
        step = STEP_NONE;
        case (level_ff)
            LVL_THREE: begin
                if (I_LOAD_CURRENT <= l2_low_ff) step = STEP_DOWN;
            end
            LVL_TWO: begin
                if (I_LOAD_CURRENT > l2_high_ff) begin
                    step = STEP_UP;
                end else if (I_LOAD_CURRENT <= l1_low_ff) begin
                    step = STEP_DOWN;
                end
            end
            default: begin
                if (I_LOAD_CURRENT > l1_high_ff) step = STEP_UP;
            end
        endcase
        if (!shed_on) step = STEP_NONE;
    end

    // Level state machine steps one level when the window expires on a steady condition, and returns to level three whenever shedding is off.
    always_comb begin
        nxt_level = level_ff;
        nxt_moved = 1'b0;
        if (!shed_on) begin
            nxt_level = LVL_THREE;
        end else if (tif.win_expired && step != STEP_NONE && step == step_ff) begin
            nxt_moved = 1'b1;
            case (level_ff)
                LVL_THREE: nxt_level = LVL_TWO;
                LVL_TWO: nxt_level = (step == STEP_UP) ? LVL_THREE : LVL_ONE;
                default: nxt_level = LVL_TWO;
            endcase
        end
    end

    // Outputs: power state two/three override every minimum and force a single phase.
    always_comb begin
        floor_ph = (pstate_ff == PSTATE_ONE) ? min_phases(control_ff[BIT_PS1_MIN_LO +: 2])
            : min_phases(control_ff[BIT_SHED_MIN_LO +: 2]);
        lvl_ph = (level_ff == LVL_ONE) ? PHASES_ONE
            : (level_ff == LVL_TWO) ? PHASES_TWO : PHASES_THREE;
        auto_skip = control_ff[BIT_SHED_EN] && control_ff[BIT_AUTO_SKIP];
        if (ps_low) begin
            nxt_phases = PHASES_ONE;
            nxt_skip = 1'b1;
        end else if (shed_on) begin
            nxt_phases = pick_phases(floor_ph, lvl_ph);
            nxt_skip = auto_skip && level_ff == LVL_ONE && nxt_phases == PHASES_ONE;
        end else if (pstate_ff == PSTATE_ONE) begin
            nxt_phases = pick_phases(floor_ph, PHASES_ONE);
            nxt_skip = 1'b0;
        end else begin
            nxt_phases = MAX_PHASES;
            nxt_skip = 1'b0;
        end
    end

    // Level, step history and output registers.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            level_ff <= LVL_THREE;
            step_ff <= STEP_NONE;
            moved_ff <= 1'b0;
            phases_ff <= PHASES_THREE;
            skip_ff <= 1'b0;
            active_ff <= 1'b0;
        end else begin
            level_ff <= nxt_level;
            step_ff <= step;
            moved_ff <= nxt_moved;
            phases_ff <= nxt_phases;
            skip_ff <= nxt_skip;
            active_ff <= shed_on;
        end
    end

    // Timer handshake; a fresh window starts after every step or condition change.
    assign tif.holdoff_len = holdoff_ff;
    assign tif.window_len = window_ff;
    assign tif.soft_start_done = I_SOFT_START_DONE;
    assign tif.win_run = (step != STEP_NONE);
    assign tif.win_restart = (step != step_ff) || moved_ff;

    assign O_REG_RDATA = rdata_ff;
    assign O_ACTIVE_PHASES = phases_ff;
    assign O_PULSE_SKIP = skip_ff;
    assign O_SHED_ACTIVE = active_ff;
endmodule

// >>> tb/shed_chk.sv
// Checker that shadows the control state and relates it to the phase outputs.
module shed_chk import shed_pkg::*; #(
    parameter int TICK_CYCLES = 4,
    parameter logic [1:0] MAX_PHASES = 2'h3
) (
    // Clock, reset and register port.
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic I_REG_WR,
    input wire logic [7:0] O_REG_RDATA,
    // Power state, load and phase outputs.
    input wire logic I_PS_CMD,
    input wire logic [1:0] I_PS_CODE,
    input wire logic [7:0] I_LOAD_CURRENT,
    input wire logic [1:0] O_ACTIVE_PHASES,
    input wire logic O_PULSE_SKIP,
    input wire logic O_SHED_ACTIVE
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] ctl_ff, nxt_ctl, win_ff, nxt_win, load_ff, nxt_load;
    logic [1:0] ps_ff, nxt_ps;
    logic [15:0] ld_ff, nxt_ld;
    // Shadow control, window and power state; count cycles of steady load.
    always_comb begin
        nxt_ctl = (I_REG_WR && I_REG_ADDR == ADDR_CONTROL) ? I_REG_WDATA & CONTROL_MASK : ctl_ff;
        nxt_win = (I_REG_WR && I_REG_ADDR == ADDR_WINDOW) ? I_REG_WDATA : win_ff;
        nxt_ps = I_PS_CMD ? I_PS_CODE : ps_ff;
        nxt_load = I_LOAD_CURRENT;
        nxt_ld = (I_LOAD_CURRENT != load_ff) ? 16'h0 : ld_ff + {15'h0, ld_ff != 16'hffff};
        if (!I_RST_N) begin
            nxt_ctl = RST_CONTROL;
            nxt_win = RST_WINDOW;
            nxt_ps = PSTATE_ZERO;
            nxt_ld = 16'h0;
        end
    end
    // Register the shadow state.
    always_ff @(posedge I_CLK) begin
        ctl_ff <= nxt_ctl;
        win_ff <= nxt_win;
        ps_ff <= nxt_ps;
        load_ff <= nxt_load;
        ld_ff <= nxt_ld;
    end
    function automatic logic [1:0] dec(input logic [1:0] f);
        return (f == 2'h0) ? PHASES_ONE : f;
    endfunction
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    // Settle times of three cycles cover the register and output stages.
    AST_RESET_OUT: assert property ($rose(I_RST_N) |-> O_ACTIVE_PHASES == MAX_PHASES
        && !O_PULSE_SKIP && !O_SHED_ACTIVE && O_REG_RDATA == 8'h00) else $error("reset outputs");
    AST_OFF_NO_SHED: assert property ((!ctl_ff[BIT_SHED_EN])[*3] |-> !O_SHED_ACTIVE)
        else $error("shedding active while disabled");
    AST_OFF_NO_SKIP: assert property ((!ctl_ff[BIT_SHED_EN] && !ps_ff[1])[*3]
        |-> !O_PULSE_SKIP) else $error("pulse skip while shedding disabled");
    AST_PS1_MIN: assert property ((!ctl_ff[BIT_SHED_EN] && ps_ff == PSTATE_ONE
        && $stable(ctl_ff) && $stable(ps_ff))[*3]
        |-> O_ACTIVE_PHASES == dec(ctl_ff[3:2])) else $error("power state one phases");
    AST_SHED_MIN: assert property ((ctl_ff[BIT_SHED_EN] && ps_ff == PSTATE_ZERO
        && $stable(ctl_ff) && $stable(ps_ff))[*3]
        |-> O_ACTIVE_PHASES >= dec(ctl_ff[1:0])) else $error("below shedding minimum");
    AST_SKIP_ONE: assert property (O_PULSE_SKIP |-> O_ACTIVE_PHASES == PHASES_ONE)
        else $error("pulse skip with several phases");
    AST_PS23_ONE: assert property (I_PS_CMD && I_PS_CODE[1] ##1 !I_PS_CMD
        |-> ##1 (O_ACTIVE_PHASES == PHASES_ONE && O_PULSE_SKIP)) else $error("low power state");
    AST_STEP_WINDOW: assert property ((ctl_ff[BIT_SHED_EN] && $stable(ctl_ff)
        && $stable(ps_ff) && ps_ff == PSTATE_ZERO)[*3] ##1 $changed(O_ACTIVE_PHASES)
        |-> int'(ld_ff) + 2 * TICK_CYCLES >= int'(win_ff) * TICK_CYCLES)
        else $error("phase step before the window ran out");
    COV_STEP: cover property (ctl_ff[BIT_SHED_EN] && $changed(O_ACTIVE_PHASES));
    COV_HOLDOFF: cover property ($rose(O_SHED_ACTIVE));
    COV_AUTO_SKIP: cover property ($rose(O_PULSE_SKIP) && ps_ff == PSTATE_ZERO);
endmodule

bind rail1_phase_shedding_regs shed_chk #(.TICK_CYCLES(TICK_CYCLES), .MAX_PHASES(MAX_PHASES))
    u_chk (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_REG_ADDR(I_REG_ADDR),
    .I_REG_WDATA(I_REG_WDATA), .I_REG_WR(I_REG_WR), .O_REG_RDATA(O_REG_RDATA),
    .I_PS_CMD(I_PS_CMD), .I_PS_CODE(I_PS_CODE), .I_LOAD_CURRENT(I_LOAD_CURRENT),
    .O_ACTIVE_PHASES(O_ACTIVE_PHASES), .O_PULSE_SKIP(O_PULSE_SKIP), .O_SHED_ACTIVE(O_SHED_ACTIVE));

// >>> tb/shed_host.sv
// Management bus host model that writes and reads the shedding registers.
module shed_host (
    // Clock and register port toward the device.
    input wire logic i_clk,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_wr,
    output logic o_rd,
    input wire logic [7:0] i_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle lines show the inverse of the last byte so stale values never look valid.
    initial begin
        o_addr = 8'h00;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // Strobe for one edge, release, and let an edge pass before the next access.
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        o_addr = addr;
        o_wdata = data;
        o_wr = 1'b1;
        @(posedge i_clk);
        #1;
        o_wr = 1'b0;
        o_addr = ~addr;
        o_wdata = ~data;
        @(posedge i_clk);
        #1;
    endtask
    // Read data stands until the next read, so it is taken one edge later.
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        o_addr = addr;
        o_rd = 1'b1;
        @(posedge i_clk);
        #1;
        o_rd = 1'b0;
        o_addr = ~addr;
        @(posedge i_clk);
        #1;
        data = i_rdata;
    endtask
endmodule

// >>> tb/rail1_phase_shedding_regs_tb.sv
// Self-checking bench for the rail-one phase shedding registers and phase control.
module rail1_phase_shedding_regs_tb import shed_pkg::*; ();
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ps_cmd = 1'b0;
    logic ss_done = 1'b0;
    logic [1:0] ps_code = 2'h0;
    logic [7:0] load = 8'hff;
    logic [7:0] addr, wdata, rdata, v, d, a;
    logic wr, rd, skip, shed;
    logic [1:0] phases, e;
    int mismatches = 0;
    int num_checks = 0;
    int seed = 32'h536a54da;
    logic [7:0] lv [6] = '{8'h70, 8'h30, 8'h50, 8'h90, 8'hb0, 8'h30};
    logic [1:0] lp [6] = '{2'h2, 2'h1, 2'h1, 2'h2, 2'h3, 2'h1};
    // A short unit keeps every holdoff and window to a few cycles.
    rail1_phase_shedding_regs #(.TICK_CYCLES(4), .MAX_PHASES(PHASES_THREE)) u_dut (
        .I_CLK(clk), .I_RST_N(rst_n), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
        .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata), .I_PS_CMD(ps_cmd),
        .I_PS_CODE(ps_code), .I_SOFT_START_DONE(ss_done), .I_LOAD_CURRENT(load),
        .O_ACTIVE_PHASES(phases), .O_PULSE_SKIP(skip), .O_SHED_ACTIVE(shed));
    shed_host u_host (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd),
        .i_rdata(rdata));
    always #10 clk = ~clk;
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic ps(input logic [1:0] code);
        ps_code = code;
        ps_cmd = 1'b1;
        tick(1);
        ps_cmd = 1'b0;
        tick(4);
    endtask
    // Poll under a bound; a step that never comes shows up as a mismatch.
    task automatic wait_phases(input logic [1:0] exp, input int limit);
        for (int i = 0; i < limit && phases !== exp; i++) tick(1);
        check("phases", {6'h0, phases}, {6'h0, exp});
    endtask
    function automatic logic [1:0] min_dec(input logic [1:0] f);
        return (f == 2'h0) ? PHASES_ONE : f;
    endfunction
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // The whole run takes under a thousand cycles, far inside this span.
    initial begin
        #400000;
        mismatches++;
        final_report();
    end
    initial begin
        tick(16);
        rst_n = 1'b1;
        // Reset values, with one unmapped byte on each side of the map.
        for (int i = 0; i < 9; i++) begin
            u_host.read_reg(8'h1f + 8'(i), v);
            d = (i == 1) ? RST_CONTROL : (i == 2) ? RST_HOLDOFF : (i == 3) ? RST_WINDOW : RST_LEVEL;
            check("reset value", v, d);
        end
        // Random writes read back; reserved control bits read zero.
        for (int i = 0; i < 24; i++) begin
            a = ADDR_CONTROL + 8'(($random(seed) & 32'h7fffffff) % 7);
            d = 8'($random(seed));
            u_host.write_reg(a, d);
            u_host.read_reg(a, v);
            check("read back", v, (a == ADDR_CONTROL) ? d & CONTROL_MASK : d);
        end
        // Every power state with shedding off and random minimum fields.
        for (int i = 0; i < 12; i++) begin
            d = 8'($random(seed)) & 8'h1f;
            u_host.write_reg(ADDR_CONTROL, d);
            ps(2'(i));
            e = (i % 4 == 0) ? PHASES_THREE : (i % 4 == 1) ? min_dec(d[3:2]) : PHASES_ONE;
            check("phases", {6'h0, phases}, {6'h0, e});
            check("pulse skip", {7'h0, skip}, {7'h0, i % 4 > 1});
            check("shed active", {7'h0, shed}, 8'h00);
        end
        ps(PSTATE_ZERO);
        u_host.write_reg(ADDR_HOLDOFF, 8'h03);
        u_host.write_reg(ADDR_WINDOW, 8'h03);
        u_host.write_reg(ADDR_L1_HIGH, 8'h60);
        u_host.write_reg(ADDR_L1_LOW, 8'h40);
        u_host.write_reg(ADDR_L2_HIGH, 8'ha0);
        u_host.write_reg(ADDR_L2_LOW, 8'h80);
        u_host.write_reg(ADDR_CONTROL, 8'h31);
        ss_done = 1'b1;
        tick(4);
        check("early shed active", {7'h0, shed}, 8'h00);
        for (int i = 0; i < 40 && shed !== 1'b1; i++) tick(1);
        check("shed active", {7'h0, shed}, 8'h01);
        // Load steps across both levels, each held past its window.
        for (int i = 0; i < 6; i++) begin
            e = phases;
            load = lv[i];
            tick(3);
            check("phases early", {6'h0, phases}, {6'h0, e});
            wait_phases(lp[i], 80);
            tick(20);
            check("phases held", {6'h0, phases}, {6'h0, lp[i]});
            check("auto skip", {7'h0, skip}, {7'h0, lp[i] == PHASES_ONE});
        end
        u_host.write_reg(ADDR_CONTROL, 8'h21);
        tick(4);
        check("skip off", {7'h0, skip}, 8'h00);
        u_host.write_reg(ADDR_CONTROL, 8'h23);
        wait_phases(PHASES_THREE, 8);
        // Power state one while shedding runs takes its floor from bits 3:2, not bits 1:0.
        u_host.write_reg(ADDR_CONTROL, 8'h28);
        ps(PSTATE_ONE);
        wait_phases(PHASES_TWO, 8);
        ps(PSTATE_TWO);
        check("ps2 phases", {6'h0, phases}, {6'h0, PHASES_ONE});
        ps(PSTATE_ZERO);
        u_host.write_reg(ADDR_CONTROL, 8'h10);
        tick(4);
        check("disabled shed", {7'h0, shed}, 8'h00);
        check("disabled skip", {7'h0, skip}, 8'h00);
        // A second reset in mid-run restores the control byte.
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        u_host.read_reg(ADDR_CONTROL, v);
        check("control after reset", v, RST_CONTROL);
        final_report();
    end
endmodule
